// [hw/bslcs_pkg.sv]
// Package for the boot strap latch and clock select block
package bslcs_pkg;
  localparam logic [31:0] ADDR_CLK_CFG2     = 32'h0000_707c;
  localparam int unsigned IDX_CLK_CFG2      = 32'h0000_1c1f;
  localparam int unsigned IDX_BOOT_CAPTURE  = 32'h0000_1c34;
  localparam logic [31:0] ADDR_BOOT_CAPTURE = 32'h0000_70d0;
  localparam logic [31:0] ADDR_BOOT_STATUS  = 32'h0000_7100;
  localparam int unsigned CLK_SRC_BIT       = 0;
  localparam int unsigned CLK_PIN_BIT       = 2;
  localparam int unsigned SEL_LO_POS        = 5;
  localparam int unsigned SEL_HI_POS        = 9;
  localparam logic        CLK_SRC_RESET     = 1'b0;
  localparam logic [3:0]  SEL_LO_RESET      = 4'h0;
  localparam logic [1:0]  SEL_HI_RESET      = 2'h0;
  localparam int unsigned HI_SAMPLE_EDGE    = 10;
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned BOOT_ENTRY_MS     = 20;
  localparam int unsigned CODE_START_MS     = 200;
  localparam int unsigned ENTRY_CYCLES      = BOOT_ENTRY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned START_CYCLES      = CODE_START_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;
  typedef enum logic [3:0] {
    BSLCS_NOR, BSLCS_NAND, BSLCS_UART_9600, BSLCS_UART_57600, BSLCS_UART_115200,
    BSLCS_SPI_1M, BSLCS_SPI_10M, BSLCS_POLL_2, BSLCS_I2C, BSLCS_CARD0, BSLCS_CARD1,
    BSLCS_POLL_1, BSLCS_HOST_PORT, BSLCS_MCSER_10M, BSLCS_MCSER_40M, BSLCS_USB
  } bslcs_mode_t;
  typedef enum logic [2:0] {
    BSLCS_P_NOR, BSLCS_P_NAND, BSLCS_P_SPI, BSLCS_P_I2C, BSLCS_P_CARD0, BSLCS_P_SEXT, BSLCS_P_SERIAL
  } bslcs_poll_t;
endpackage : bslcs_pkg

// [hw/bslcs_top.sv]
// Boot strap latch, boot mode decode, boot sequencer and clock select
`timescale 1ns/1ps
// Contract
// (RQ1) Latch four low straps into bits 8:5 at first edge after reset release.
// (RQ2) Strap capture tolerates 10 to 12 cycle reset synchronisation latency.
// (RQ3) Codes 0000/0001 decode NOR and NAND boot, generator bypassed.
// (RQ4) Codes 0010-0100 decode UART 9600/57600/115200, generator times three.
// (RQ5) Codes 0101/0110 decode SPI below 1 MHz / 10 MHz, times three.
// (RQ6) Code 0111 polls NOR, NAND, SPI, I2C, card0, serial port, UART/USB endlessly.
// (RQ7) Code 1000 decodes I2C 16-bit EEPROM at 400 kHz, bypass.
// (RQ8) Codes 1001/1010 decode card controller 0 / 1 boot, bypass.
// (RQ9) Code 1011 polls NOR, NAND, SPI, I2C, card0, card1, UART/USB endlessly.
// (RQ10) Code 1100 decodes host port 16-bit multiplexed boot, times three.
// (RQ11) Codes 1101/1110 decode serial port flash boot at 10 / 40 MHz.
// (RQ12) Code 1111 decodes USB boot, times three.
// (RQ13) Polling stays on a card controller while its command line is low.
// (RQ14) Bit 2 of clock config reflects the clock pin level.
// (RQ15) Bit 0 of clock config selects bypass (0) or generator (1), resets 0.
// (RQ16) Software writes zero to reserved bits 3 and 1.
// (RQ17) Full six-bit strap pattern is captured into the boot selection field.
// (RQ18) Boot sequence starts automatically after every reset.
// (RQ19) Boot entry to reset release within 20 ms.
// (RQ20) User code starts no earlier than 200 ms after boot begins.
// (RQ21) Upper two selection bits 10:9 sampled on tenth edge after reset.
// (RQ22) Latched selection holds until next reset.
module bslcs_top #(
  parameter int unsigned START_WAIT = bslcs_pkg::START_CYCLES,
  parameter int unsigned ENTRY_WAIT = bslcs_pkg::ENTRY_CYCLES
) (
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  input  wire logic [5:0]               strap_pins,
  input  wire logic                     clock_pin_state,
  input  wire logic                     card_command_line,
  input  wire logic                     image_valid,
  output logic                          system_clock_source,
  output logic                          clk_mult_three,
  output bslcs_pkg::bslcs_mode_t        boot_mode,
  output bslcs_pkg::bslcs_poll_t        poll_target,
  output logic                          boot_active,
  output logic                          user_start,
  input  wire logic [31:0]              s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [31:0]              s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready
);
  import bslcs_pkg::*;

  logic [3:0]  edge_cnt_q;
  logic        lo_taken_q;
  logic        hi_taken_q;
  logic [3:0]  sel_lo_q;
  logic [1:0]  sel_hi_q;
  logic        clk_src_q;
  logic        pin_q;
  logic [31:0] wait_cnt_q;
  logic        loaded_q;
  logic        aw_q;
  logic        w_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        poll_run;

  // Edge count since reset release; reset is synchronised by the system outside
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      edge_cnt_q <= 4'h0;
    end else if (edge_cnt_q != 4'hf) begin
      edge_cnt_q <= edge_cnt_q + 4'h1; // RQ2
    end
  end

  // Low strap capture on the first edge, then frozen
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sel_lo_q   <= SEL_LO_RESET;
      lo_taken_q <= 1'b0;
    end else if (!lo_taken_q) begin
      sel_lo_q   <= strap_pins[3:0]; // RQ1 RQ17
      lo_taken_q <= 1'b1; // RQ22
    end
  end

  // High strap capture on the tenth edge, then frozen
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sel_hi_q   <= SEL_HI_RESET;
      hi_taken_q <= 1'b0;
    end else if (!hi_taken_q && edge_cnt_q == 4'(HI_SAMPLE_EDGE - 1)) begin
      sel_hi_q   <= strap_pins[5:4]; // RQ21 RQ17
      hi_taken_q <= 1'b1; // RQ22
    end
  end

  // Clock pin status follows the pin
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= clock_pin_state; // RQ14
    end
  end

  // Mode decode from the captured code
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      boot_mode      <= BSLCS_NOR;
      clk_mult_three <= 1'b0;
    end else begin
      boot_mode <= bslcs_mode_t'(sel_lo_q); // RQ3 RQ7 RQ8 RQ10 RQ11
      case (bslcs_mode_t'(sel_lo_q))
        BSLCS_UART_9600, BSLCS_UART_57600, BSLCS_UART_115200: clk_mult_three <= 1'b1; // RQ4
        BSLCS_SPI_1M, BSLCS_SPI_10M:                          clk_mult_three <= 1'b1; // RQ5
        BSLCS_HOST_PORT:                                      clk_mult_three <= 1'b1; // RQ10
        BSLCS_USB:                                            clk_mult_three <= 1'b1; // RQ12
        default:                                              clk_mult_three <= 1'b0; // RQ3 RQ7 RQ8
      endcase
    end
  end

  // Polling walk; advances on a missing image, stays on a card while command is low
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      poll_target <= BSLCS_P_NOR;
    end else if (lo_taken_q && !image_valid &&
                 (sel_lo_q == BSLCS_POLL_1 || sel_lo_q == BSLCS_POLL_2)) begin
      case (poll_target)
        BSLCS_P_NOR:    poll_target <= BSLCS_P_NAND;
        BSLCS_P_NAND:   poll_target <= BSLCS_P_SPI;
        BSLCS_P_SPI:    poll_target <= BSLCS_P_I2C;
        BSLCS_P_I2C:    poll_target <= BSLCS_P_CARD0;
        BSLCS_P_CARD0: begin
          if (card_command_line) begin
            poll_target <= BSLCS_P_SEXT; // RQ13 RQ6 RQ9
          end
        end
        BSLCS_P_SEXT: begin
          if (sel_lo_q == BSLCS_POLL_2 || card_command_line) begin
            poll_target <= BSLCS_P_SERIAL; // RQ6 RQ9 RQ13
          end
        end
        BSLCS_P_SERIAL: poll_target <= BSLCS_P_NOR; // RQ6 RQ9
        default:        poll_target <= BSLCS_P_NOR;
      endcase
    end
  end

  // Boot sequence runs from each reset release; user code waits the settle time
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      boot_active <= 1'b0;
      wait_cnt_q  <= 32'h0;
      loaded_q    <= 1'b0;
      user_start  <= 1'b0;
    end else begin
      boot_active <= !user_start; // RQ18 RQ19
      if (wait_cnt_q < START_WAIT) begin
        wait_cnt_q <= wait_cnt_q + 32'h1;
      end
      if (image_valid && hi_taken_q) begin
        loaded_q <= 1'b1;
      end
      if (loaded_q && wait_cnt_q >= START_WAIT) begin
        user_start <= 1'b1; // RQ20
      end
    end
  end

  // Write channel: address and data taken in either order
  assign wr_go = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awaddr_q      <= 32'h0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q[31:2] == ADDR_CLK_CFG2[31:2] ||
                         awaddr_q[31:2] == ADDR_BOOT_CAPTURE[31:2] ||
                         awaddr_q[31:2] == ADDR_BOOT_STATUS[31:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Clock source select; reserved bits ignored on write
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clk_src_q <= CLK_SRC_RESET;
    end else if (wr_go && awaddr_q[31:2] == ADDR_CLK_CFG2[31:2] && wstrb_q[0]) begin
      clk_src_q <= wdata_q[CLK_SRC_BIT]; // RQ15 RQ16
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      system_clock_source <= CLK_SRC_RESET;
    end else begin
      system_clock_source <= clk_src_q; // RQ15
    end
  end

  // Read mux
  always_comb begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    if (s_axi_araddr[31:2] == ADDR_CLK_CFG2[31:2]) begin
      rd_val[CLK_SRC_BIT] = clk_src_q;
      rd_val[CLK_PIN_BIT] = pin_q; // RQ14
    end else if (s_axi_araddr[31:2] == ADDR_BOOT_CAPTURE[31:2]) begin
      rd_val[SEL_LO_POS +: 4] = sel_lo_q; // RQ1 RQ17
      rd_val[SEL_HI_POS +: 2] = sel_hi_q; // RQ21
    end else if (s_axi_araddr[31:2] == ADDR_BOOT_STATUS[31:2]) begin
      rd_val[2:0] = poll_target;
      rd_val[3]   = boot_active;
      rd_val[4]   = user_start;
      rd_val[5]   = clk_mult_three;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  sequence seq_first_edge;
    !lo_taken_q ##1 lo_taken_q;
  endsequence

  chk_low_strap_latch: assert property (@(posedge ref_clk) disable iff (reset) // RQ1
    seq_first_edge |-> sel_lo_q == $past(strap_pins[3:0]))
    else $error("low strap field not captured on first edge");

  chk_high_strap_latch: assert property (@(posedge ref_clk) disable iff (reset) // RQ21
    $rose(hi_taken_q) |-> edge_cnt_q == 4'(HI_SAMPLE_EDGE) && sel_hi_q == $past(strap_pins[5:4]))
    else $error("high strap field not captured on tenth edge");

  chk_field_hold: assert property (@(posedge ref_clk) disable iff (reset) // RQ22
    lo_taken_q && hi_taken_q |=> $stable(sel_lo_q) && $stable(sel_hi_q))
    else $error("boot selection changed after capture");

  chk_mult_decode: assert property (@(posedge ref_clk) disable iff (reset) // RQ4
    lo_taken_q && sel_lo_q inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hc, 4'hf} |=> clk_mult_three)
    else $error("times three not set for generator mode");

  chk_bypass_decode: assert property (@(posedge ref_clk) disable iff (reset) // RQ3
    lo_taken_q && sel_lo_q inside {4'h0, 4'h1, 4'h8, 4'h9, 4'ha} |=> !clk_mult_three)
    else $error("bypass mode decoded with times three");

  chk_card_stay: assert property (@(posedge ref_clk) disable iff (reset) // RQ13
    poll_target == BSLCS_P_CARD0 && !card_command_line |=> poll_target == BSLCS_P_CARD0)
    else $error("polling left card while command line low");

  chk_pin_status: assert property (@(posedge ref_clk) disable iff (reset) // RQ14
    lo_taken_q |=> pin_q == $past(clock_pin_state))
    else $error("clock pin status does not follow the pin");

  chk_src_output: assert property (@(posedge ref_clk) disable iff (reset) // RQ15
    ##1 system_clock_source == $past(clk_src_q))
    else $error("system clock source does not follow register");

  chk_user_wait: assert property (@(posedge ref_clk) disable iff (reset) // RQ20
    $rose(user_start) |-> $past(wait_cnt_q) >= START_WAIT)
    else $error("user code started before settle time");

  chk_boot_auto: assert property (@(posedge ref_clk) disable iff (reset) // RQ18
    lo_taken_q && !user_start |=> boot_active)
    else $error("boot sequence not active after reset");

  assign poll_run = lo_taken_q && !image_valid && (sel_lo_q == BSLCS_POLL_1 || sel_lo_q == BSLCS_POLL_2);

  sequence seq_card1_wait;
    poll_run && sel_lo_q == BSLCS_POLL_1 && poll_target == BSLCS_P_SEXT && !card_command_line;
  endsequence

  chk_card1_stay: assert property (@(posedge ref_clk) disable iff (reset) // RQ13
    seq_card1_wait |=> poll_target == BSLCS_P_SEXT)
    else $error("polling left card 1 while command line low");

  chk_poll2_skip: assert property (@(posedge ref_clk) disable iff (reset) // RQ6
    poll_run && sel_lo_q == BSLCS_POLL_2 && poll_target == BSLCS_P_SEXT |=> poll_target == BSLCS_P_SERIAL)
    else $error("second polling mode did not move on to serial port");

  chk_poll_card0: assert property (@(posedge ref_clk) disable iff (reset) // RQ6 RQ9
    poll_run && poll_target == BSLCS_P_I2C |=> poll_target == BSLCS_P_CARD0)
    else $error("polling did not move from I2C to card 0");

  chk_poll_wrap: assert property (@(posedge ref_clk) disable iff (reset) // RQ6 RQ9
    poll_run && poll_target == BSLCS_P_SERIAL |=> poll_target == BSLCS_P_NOR)
    else $error("polling did not retry from NOR");

  chk_poll_freeze: assert property (@(posedge ref_clk) disable iff (reset) // RQ9
    lo_taken_q && image_valid |=> $stable(poll_target))
    else $error("polling moved while an image was found");

  chk_serial_slow: assert property (@(posedge ref_clk) disable iff (reset) // RQ11
    lo_taken_q && sel_lo_q == 4'hd |=> boot_mode == BSLCS_MCSER_10M)
    else $error("serial port 10 MHz boot not decoded");

  chk_serial_fast: assert property (@(posedge ref_clk) disable iff (reset) // RQ11
    lo_taken_q && sel_lo_q == 4'he |=> boot_mode == BSLCS_MCSER_40M)
    else $error("serial port 40 MHz boot not decoded");

  chk_host_decode: assert property (@(posedge ref_clk) disable iff (reset) // RQ10
    lo_taken_q && sel_lo_q == 4'hc |=> boot_mode == BSLCS_HOST_PORT && clk_mult_three)
    else $error("host port boot not decoded");

  chk_boot_start: assert property (@(posedge ref_clk) disable iff (reset) // RQ18
    seq_first_edge |-> boot_active && !user_start)
    else $error("boot sequence not started on first edge");

  chk_src_reset: assert property (@(posedge ref_clk) disable iff (reset) // RQ15
    seq_first_edge |-> !clk_src_q && !system_clock_source)
    else $error("clock source not bypass after reset");

  chk_src_write: assert property (@(posedge ref_clk) disable iff (reset) // RQ15
    wr_go && awaddr_q[31:2] == ADDR_CLK_CFG2[31:2] && wstrb_q[0] |=> clk_src_q == $past(wdata_q[CLK_SRC_BIT]))
    else $error("clock source write not applied");

  chk_user_sticky: assert property (@(posedge ref_clk) disable iff (reset) // RQ20
    user_start |=> user_start && !boot_active)
    else $error("user start dropped or boot still active");
endmodule : bslcs_top

// [dv/bslcs_board.sv]
// Board model driving the strap pins, the clock select pin and the card command line
`timescale 1ns/1ps
module bslcs_board (
  input  wire logic [5:0] strap_set,
  input  wire logic       clk_sel_set,
  input  wire logic       cmd_high_set,
  output logic      [5:0] strap_pins,
  output logic            clock_pin_state,
  output logic            card_command_line
);
  // Straps are static board levels
  assign strap_pins        = strap_set;
  assign clock_pin_state   = clk_sel_set;
  // Board holds the command line high or low on request
  assign card_command_line = cmd_high_set;
endmodule : bslcs_board

// [dv/bslcs_testbench.sv]
// Self-checking testbench for the boot strap latch and clock select block
`timescale 1ns/1ps
module testbench;
  import bslcs_pkg::*;
  localparam int unsigned START_WAIT_TB = 50;
  localparam logic [15:0] X3_SET        = 16'h907c;
  localparam logic [15:0] X3_KNOWN      = 16'h977f;
  logic        ref_clk       = 1'b0;
  logic        reset         = 1'b1;
  logic [5:0]  strap_set     = 6'h00;
  logic        clk_sel_set   = 1'b0;
  logic        cmd_high_set  = 1'b1;
  logic        image_valid   = 1'b0;
  logic [31:0] s_axi_awaddr  = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'h0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [31:0] s_axi_araddr  = 32'h0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic [5:0]  strap_pins;
  logic        clock_pin_state;
  logic        card_command_line;
  logic        system_clock_source;
  logic        clk_mult_three;
  bslcs_mode_t boot_mode;
  bslcs_poll_t poll_target;
  logic        boot_active;
  logic        user_start;
  logic        s_axi_awready;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  int          fail_count    = 0;
  int          tests_run     = 0;

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  bslcs_board i_board (.strap_set(strap_set), .clk_sel_set(clk_sel_set), .cmd_high_set(cmd_high_set),
    .strap_pins(strap_pins), .clock_pin_state(clock_pin_state), .card_command_line(card_command_line));

  bslcs_top #(.START_WAIT(START_WAIT_TB)) i_dut (.ref_clk(ref_clk), .reset(reset), .strap_pins(strap_pins),
    .clock_pin_state(clock_pin_state), .card_command_line(card_command_line), .image_valid(image_valid),
    .system_clock_source(system_clock_source), .clk_mult_three(clk_mult_three), .boot_mode(boot_mode),
    .poll_target(poll_target), .boot_active(boot_active), .user_start(user_start),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  task automatic stop_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic check(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      $display("CHECK FAILED at %0t: %s", $time, msg);
      fail_count++;
    end
  endtask : check

  // Straps are set while reset is high, reset is held for 12 cycles
  task automatic do_reset(input logic [5:0] s, input logic sel);
    @(posedge ref_clk);
    reset       <= 1'b1;
    strap_set   <= s;
    clk_sel_set <= sel;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
  endtask : do_reset

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) begin
      check(1'b0, "write response timeout");
      stop_test();
    end
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) begin
      check(1'b0, "read response timeout");
      stop_test();
    end
  endtask : axi_read

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [2:0]  p;
    int          n;
    // Every boot code, with the clock-frequency bits and clock pin varied
    for (int c = 0; c < 16; c++) begin
      do_reset({c[1:0], c[3:0]}, c[0]);
      repeat (15) @(posedge ref_clk);
      check(boot_mode === bslcs_mode_t'(c[3:0]), "boot mode decode");
      if (X3_KNOWN[c]) check(clk_mult_three === X3_SET[c], "multiplier select");
      axi_read(ADDR_BOOT_CAPTURE, d, r);
      check(d === {21'h0, c[1:0], c[3:0], 5'h00} && r === RESP_OKAY, "capture field");
      axi_read(ADDR_CLK_CFG2, d, r);
      check(d === {29'h0, c[0], 2'h0} && r === RESP_OKAY, "clock config reset and pin");
    end
    $display("Test decode done");
    // Straps move after capture; register writes to the capture are ignored
    strap_set <= 6'h00;
    axi_write(ADDR_BOOT_CAPTURE, 32'h0000_ffff, r);
    check(r === RESP_OKAY, "capture write response");
    axi_read(ADDR_BOOT_CAPTURE, d, r);
    check(d === 32'h0000_07e0 && boot_mode === BSLCS_USB, "capture holds");
    $display("Test hold done");
    // Clock source select
    axi_write(ADDR_CLK_CFG2, 32'h0000_0001, r);
    repeat (3) @(posedge ref_clk);
    check(r === RESP_OKAY && system_clock_source === 1'b1, "generator selected");
    axi_read(ADDR_CLK_CFG2, d, r);
    check(d === 32'h0000_0005, "clock config readback");
    axi_write(ADDR_CLK_CFG2, 32'h0000_0000, r);
    repeat (3) @(posedge ref_clk);
    check(system_clock_source === 1'b0, "bypass selected");
    $display("Test clock select done");
    // Unmapped address
    axi_write(32'h0000_7200, 32'h0000_0001, r);
    check(r === RESP_SLVERR, "unmapped write");
    axi_read(32'h0000_7200, d, r);
    check(r === RESP_SLVERR, "unmapped read");
    $display("Test unmapped done");
    // Polling order for both polling codes, card wait in the first polling mode
    for (int k = 0; k < 2; k++) begin
      cmd_high_set <= (k == 0);
      do_reset(k ? 6'h0b : 6'h07, 1'b0);
      repeat (40) @(posedge ref_clk);
      if (k) begin
        check(poll_target === BSLCS_P_CARD0, "poll waits on card 0 line");
        cmd_high_set <= 1'b1;
        @(posedge ref_clk);
        cmd_high_set <= 1'b0;
        repeat (5) @(posedge ref_clk);
        check(poll_target === BSLCS_P_SEXT, "poll waits on card 1 line");
      end
      cmd_high_set <= 1'b1;
      repeat (2) @(posedge ref_clk);
      p = poll_target;
      repeat (14) begin
        @(posedge ref_clk);
        check(poll_target === ((p == 3'd6) ? 3'd0 : p + 3'd1), "poll order");
        p = poll_target;
      end
    end
    $display("Test polling done");
    // Automatic boot start and user code start delay
    image_valid <= 1'b1;
    do_reset(6'h00, 1'b0);
    repeat (2) @(posedge ref_clk);
    check(boot_active === 1'b1 && user_start === 1'b0, "boot starts after reset");
    n = 2;
    while (user_start !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    check(user_start === 1'b1 && n >= START_WAIT_TB, "user start delay");
    axi_read(ADDR_BOOT_STATUS, d, r);
    check(d[4:3] === 2'b10 && boot_active === 1'b0, "boot finished");
    $display("Test user start done");
    stop_test();
  end
endmodule : testbench
